/* File: verilog/lcdhp_pkg.sv */
// package for the host-side controller of the lcd controller bus port
package lcdhp_pkg;
  // -------------------------------------------------------------
  // widths
  // -------------------------------------------------------------
  localparam int unsigned LCDHP_AW = 17; // device address width
  localparam int unsigned LCDHP_DW = 16; // device data width
  localparam int unsigned LCDHP_RW = 32; // own register data width
  localparam int unsigned LCDHP_RA = 4;  // own register address width

  // -------------------------------------------------------------
  // own register offsets (byte addresses)
  // -------------------------------------------------------------
  localparam logic [LCDHP_RA-1:0] LCDHP_REG_ADDR = 4'h0; // target address
  localparam logic [LCDHP_RA-1:0] LCDHP_REG_WDATA = 4'h4; // write data
  localparam logic [LCDHP_RA-1:0] LCDHP_REG_CTRL = 4'h8; // command / straps
  localparam logic [LCDHP_RA-1:0] LCDHP_REG_STAT = 4'hC; // status and read data

  // -------------------------------------------------------------
  // control register fields
  // -------------------------------------------------------------
  localparam int unsigned LCDHP_CTRL_GO = 0;     // write 1: start cycle
  localparam int unsigned LCDHP_CTRL_RD = 1;     // 1 read, 0 write
  localparam int unsigned LCDHP_CTRL_BYTE = 2;   // 1 byte transfer
  localparam int unsigned LCDHP_CTRL_ENDIAN = 3; // endian strap level
  localparam int unsigned LCDHP_CTRL_RESET = 4;  // hold device in reset

  // status register fields
  localparam int unsigned LCDHP_STAT_BUSY = 16;  // cycle in flight
  localparam int unsigned LCDHP_STAT_DONE = 17;  // sticky, cleared by go
  localparam int unsigned LCDHP_STAT_TMO = 18;   // sticky wait timeout

  // -------------------------------------------------------------
  // reset values and strap levels
  // -------------------------------------------------------------
  localparam logic LCDHP_STRAP_GENERIC = 1'b1; // straps for 16-bit generic mode
  localparam logic LCDHP_ENDIAN_RST = 1'b0;    // little endian
  localparam logic LCDHP_DEV_RST_RST = 1'b1;   // device held in reset
  localparam logic [LCDHP_DW-1:0] LCDHP_DATA_RST = 16'h0000;
  localparam logic [LCDHP_AW-1:0] LCDHP_ADDR_RST = 17'h0_0000;

  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam int unsigned LCDHP_CLK_MHZ = 50;
  localparam int unsigned LCDHP_BCLK_DIV = 4;  // sys cycles per bus clock half
  localparam int unsigned LCDHP_SETUP_NS = 40; // strobe setup after address
  localparam int unsigned LCDHP_SETUP_CYC = (LCDHP_SETUP_NS * LCDHP_CLK_MHZ + 999) / 1000;
  localparam int unsigned LCDHP_WAIT_SEEN_NS = 100; // time for wait to assert
  localparam int unsigned LCDHP_WAIT_SEEN_CYC = (LCDHP_WAIT_SEEN_NS * LCDHP_CLK_MHZ + 999) / 1000;
  localparam int unsigned LCDHP_TMO_CYC = 4000; // give up waiting
  localparam int unsigned LCDHP_CW = 12;        // counter width

  // -------------------------------------------------------------
  // states
  // -------------------------------------------------------------
  typedef enum logic [2:0] {
    LCDHP_IDLE = 3'b000,
    LCDHP_SETUP = 3'b001,
    LCDHP_STROBE = 3'b010,
    LCDHP_HOLD = 3'b011
  } lcdhp_state_e;

  // pins toward the device
  typedef struct packed {
    logic [LCDHP_AW-1:0] addr;
    logic [LCDHP_DW-1:0] dout;
    logic doe_n;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic hb_n;
    logic bclk;
    logic rst_n;
    logic [2:0] cfg;
    logic endian;
    logic bs_n;
    logic rdwr;
  } lcdhp_pins_s;

  // all state of the controller except the input synchronisers
  typedef struct packed {
    lcdhp_state_e st;
    lcdhp_pins_s pin;
    logic [LCDHP_AW-1:0] areg;
    logic [LCDHP_DW-1:0] wreg;
    logic [LCDHP_DW-1:0] rdata;
    logic rd;
    logic byte_op;
    logic endian_cfg;
    logic dev_rst;
    logic done;
    logic tmo;
    logic [LCDHP_CW-1:0] cnt;
    logic [LCDHP_CW-1:0] div;
    logic [LCDHP_RW-1:0] rbus;
  } lcdhp_state_s;
endpackage

/* File: verilog/lcdhp_host.sv */
// host-side controller driving the lcd controller generic bus port
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// RULE_01 - drive all config straps high at reset
// RULE_02 - endian strap level set by software
// RULE_03 - drive free-running bus clock to device
// RULE_04 - seventeen address and sixteen data lines direct
// RULE_05 - device data on low-order host lines
// RULE_06 - assert chip select for device window only
// RULE_07 - high-byte strobe qualifies upper byte
// RULE_08 - write strobe low only in writes
// RULE_09 - read strobe low only in reads
// RULE_10 - device holds wait low while arbitrating
// RULE_11 - extend cycle until wait released; the strobe ends with tmo set after LCDHP_TMO_CYC cycles if wait stays low
// RULE_12 - tie bus status and read/write high
// RULE_13 - device takes controls asynchronously
// RULE_14 - chip select with one strobe, wait inserts
// RULE_15 - upper-byte enable low for 16-bit
// RULE_16 - window is 128 kbytes of address
// RULE_17 - host pin-mode register selects external controller
// RULE_18 - host maps pins to byte enable, ready
// RULE_19 - invert wait if host wants active high
// RULE_20 - device ignores strobes when deselected
module lcdhp_host (
  // clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  // software register port
  input wire logic [lcdhp_pkg::LCDHP_RA-1:0] REG_ADDR_IN,
  input wire logic [lcdhp_pkg::LCDHP_RW-1:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [lcdhp_pkg::LCDHP_RW-1:0] REG_RDATA_OUT,
  // device bus
  output logic [lcdhp_pkg::LCDHP_AW-1:0] HOST_ADDR_OUT,
  input wire logic [lcdhp_pkg::LCDHP_DW-1:0] HOST_DATA_IN,
  output logic [lcdhp_pkg::LCDHP_DW-1:0] HOST_DATA_OUT,
  output logic HOST_DATA_OE_N_OUT,
  output logic PROC_LCD_WINDOW_SEL_N_OUT,
  output logic READ_STROBE_N_OUT,
  output logic WRITE_STROBE_N_OUT,
  output logic HIGH_BYTE_STROBE_N_OUT,
  input wire logic WAIT_N_IN,
  // clock, reset and straps toward device
  output logic HOST_BUS_CLOCK_OUT,
  output logic DEV_RESET_N_OUT,
  output logic BUS_CFG_STRAP_0_OUT,
  output logic BUS_CFG_STRAP_1_OUT,
  output logic BUS_CFG_STRAP_2_OUT,
  output logic ENDIAN_STRAP_OUT,
  output logic BUS_STATUS_STRAP_N_OUT,
  output logic RD_WR_STRAP_OUT
);
  import lcdhp_pkg::*;

  // -------------------------------------------------------------
  // derived counts
  // -------------------------------------------------------------
  localparam logic [LCDHP_CW-1:0] SETUP_C = LCDHP_CW'(LCDHP_SETUP_CYC);
  localparam logic [LCDHP_CW-1:0] SEEN_C = LCDHP_CW'(LCDHP_WAIT_SEEN_CYC);
  localparam logic [LCDHP_CW-1:0] TMO_C = LCDHP_CW'(LCDHP_TMO_CYC);
  localparam logic [LCDHP_CW-1:0] DIV_C = LCDHP_CW'(LCDHP_BCLK_DIV - 1);
  localparam logic [LCDHP_CW-1:0] ONE_C = 12'h001;
  localparam logic [LCDHP_CW-1:0] ZERO_C = 12'h000;

  lcdhp_state_s s_q; // registered state
  lcdhp_state_s s_d; // next state
  logic wait_m_q; // synchroniser first stage, read only by wait_s_q
  logic wait_s_q; // synchronised wait level
  logic [LCDHP_DW-1:0] din_m_q; // data synchroniser stage one
  logic [LCDHP_DW-1:0] din_s_q; // data synchroniser stage two

  // -------------------------------------------------------------
  // input synchronisers
  // -------------------------------------------------------------
  // wait and read data come from another domain; two flops each
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      wait_m_q <= 1'b1;
      wait_s_q <= 1'b1;
      din_m_q <= LCDHP_DATA_RST;
      din_s_q <= LCDHP_DATA_RST;
    end else begin
      wait_m_q <= WAIT_N_IN;
      wait_s_q <= wait_m_q;
      din_m_q <= HOST_DATA_IN;
      din_s_q <= din_m_q;
    end
  end

  // -------------------------------------------------------------
  // next-state logic
  // -------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rbus = '0;
    // bus clock divider, free running
    if (s_q.div == DIV_C) begin
      s_d.div = ZERO_C;
      s_d.pin.bclk = ~s_q.pin.bclk; // RULE_03
    end else begin
      s_d.div = s_q.div + ONE_C;
    end
    // fixed straps for the generic 16-bit mode
    s_d.pin.cfg = {3{LCDHP_STRAP_GENERIC}}; // RULE_01
    s_d.pin.bs_n = LCDHP_STRAP_GENERIC; // RULE_01 RULE_12
    s_d.pin.rdwr = 1'b1; // RULE_12
    // endian strap only matters while the device is in reset
    s_d.pin.endian = s_q.endian_cfg; // RULE_02
    s_d.pin.rst_n = ~s_q.dev_rst;

    // register writes; go is refused while busy
    if (REG_WR_IN) begin
      if (REG_ADDR_IN == LCDHP_REG_ADDR) begin
        s_d.areg = REG_WDATA_IN[LCDHP_AW-1:0]; // RULE_04 RULE_16
      end else if (REG_ADDR_IN == LCDHP_REG_WDATA) begin
        s_d.wreg = REG_WDATA_IN[LCDHP_DW-1:0];
      end else if (REG_ADDR_IN == LCDHP_REG_CTRL) begin
        s_d.endian_cfg = REG_WDATA_IN[LCDHP_CTRL_ENDIAN];
        s_d.dev_rst = REG_WDATA_IN[LCDHP_CTRL_RESET];
        if (REG_WDATA_IN[LCDHP_CTRL_GO] && s_q.st == LCDHP_IDLE && !s_q.dev_rst) begin
          s_d.rd = REG_WDATA_IN[LCDHP_CTRL_RD];
          s_d.byte_op = REG_WDATA_IN[LCDHP_CTRL_BYTE];
          s_d.done = 1'b0;
          s_d.tmo = 1'b0;
          s_d.cnt = ZERO_C;
          s_d.st = LCDHP_SETUP;
        end
      end
    end

    // register reads, data the cycle after
    if (REG_RD_IN) begin
      if (REG_ADDR_IN == LCDHP_REG_ADDR) begin
        s_d.rbus = LCDHP_RW'(s_q.areg);
      end else if (REG_ADDR_IN == LCDHP_REG_WDATA) begin
        s_d.rbus = LCDHP_RW'(s_q.wreg);
      end else if (REG_ADDR_IN == LCDHP_REG_CTRL) begin
        s_d.rbus[LCDHP_CTRL_ENDIAN] = s_q.endian_cfg;
        s_d.rbus[LCDHP_CTRL_RESET] = s_q.dev_rst;
      end else if (REG_ADDR_IN == LCDHP_REG_STAT) begin
        s_d.rbus[LCDHP_DW-1:0] = s_q.rdata;
        s_d.rbus[LCDHP_STAT_BUSY] = (s_q.st != LCDHP_IDLE);
        s_d.rbus[LCDHP_STAT_DONE] = s_q.done;
        s_d.rbus[LCDHP_STAT_TMO] = s_q.tmo;
      end
    end

    // bus cycle sequencer
    case (s_q.st)
      LCDHP_IDLE: begin
        // deselected, strobes inactive, data released
        s_d.pin.cs_n = 1'b1; // RULE_06 RULE_20
        s_d.pin.rd_n = 1'b1;
        s_d.pin.wr_n = 1'b1;
        s_d.pin.hb_n = 1'b1;
        s_d.pin.doe_n = 1'b1;
      end
      LCDHP_SETUP: begin
        // address and select first, strobe after setup time
        s_d.pin.addr = s_q.areg; // RULE_04
        s_d.pin.cs_n = 1'b0; // RULE_06 RULE_14 RULE_17
        // device data on low-order lines, so no lane swap here
        s_d.pin.dout = s_q.wreg; // RULE_05
        s_d.pin.doe_n = s_q.rd; // RULE_08
        s_d.pin.hb_n = s_q.byte_op; // RULE_07 RULE_15 RULE_18
        s_d.cnt = s_q.cnt + ONE_C;
        if (s_q.cnt >= SETUP_C) begin
          s_d.cnt = ZERO_C;
          s_d.pin.rd_n = ~s_q.rd; // RULE_09 RULE_14
          s_d.pin.wr_n = s_q.rd; // RULE_08 RULE_14
          s_d.st = LCDHP_STROBE;
        end
      end
      LCDHP_STROBE: begin
        // give wait time to appear, then extend while it is low
        s_d.cnt = s_q.cnt + ONE_C;
        if (s_q.cnt >= SEEN_C && wait_s_q) begin // RULE_11 RULE_19
          s_d.cnt = ZERO_C;
          if (s_q.rd) begin
            s_d.rdata = din_s_q;
          end
          s_d.pin.rd_n = 1'b1;
          s_d.pin.wr_n = 1'b1;
          s_d.done = 1'b1;
          s_d.st = LCDHP_HOLD;
        end else if (s_q.cnt == TMO_C) begin
          // stuck wait: abandon rather than hang the port
          s_d.cnt = ZERO_C;
          s_d.pin.rd_n = 1'b1;
          s_d.pin.wr_n = 1'b1;
          s_d.tmo = 1'b1;
          s_d.st = LCDHP_HOLD;
        end
      end
      LCDHP_HOLD: begin
        // hold address and data one setup time after strobe
        s_d.cnt = s_q.cnt + ONE_C;
        if (s_q.cnt >= SETUP_C) begin
          s_d.cnt = ZERO_C;
          s_d.pin.cs_n = 1'b1;
          s_d.pin.hb_n = 1'b1;
          s_d.pin.doe_n = 1'b1;
          s_d.st = LCDHP_IDLE;
        end
      end
      default: begin
        s_d.st = LCDHP_IDLE;
      end
    endcase

    // device reset aborts any cycle
    if (s_q.dev_rst) begin
      s_d.st = LCDHP_IDLE;
      s_d.pin.cs_n = 1'b1;
      s_d.pin.rd_n = 1'b1;
      s_d.pin.wr_n = 1'b1;
      s_d.pin.hb_n = 1'b1;
      s_d.pin.doe_n = 1'b1;
    end
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      s_q <= '0;
      s_q.st <= LCDHP_IDLE;
      s_q.pin.doe_n <= 1'b1;
      s_q.pin.cs_n <= 1'b1;
      s_q.pin.rd_n <= 1'b1;
      s_q.pin.wr_n <= 1'b1;
      s_q.pin.hb_n <= 1'b1;
      s_q.pin.cfg <= {3{LCDHP_STRAP_GENERIC}};
      s_q.pin.bs_n <= LCDHP_STRAP_GENERIC;
      s_q.pin.rdwr <= 1'b1;
      s_q.pin.endian <= LCDHP_ENDIAN_RST;
      s_q.endian_cfg <= LCDHP_ENDIAN_RST;
      s_q.dev_rst <= LCDHP_DEV_RST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // -------------------------------------------------------------
  // outputs, all from flops
  // -------------------------------------------------------------
  assign REG_RDATA_OUT = s_q.rbus;
  assign HOST_ADDR_OUT = s_q.pin.addr;
  assign HOST_DATA_OUT = s_q.pin.dout;
  assign HOST_DATA_OE_N_OUT = s_q.pin.doe_n;
  assign PROC_LCD_WINDOW_SEL_N_OUT = s_q.pin.cs_n;
  assign READ_STROBE_N_OUT = s_q.pin.rd_n;
  assign WRITE_STROBE_N_OUT = s_q.pin.wr_n;
  assign HIGH_BYTE_STROBE_N_OUT = s_q.pin.hb_n;
  assign HOST_BUS_CLOCK_OUT = s_q.pin.bclk;
  assign DEV_RESET_N_OUT = s_q.pin.rst_n;
  assign BUS_CFG_STRAP_0_OUT = s_q.pin.cfg[0];
  assign BUS_CFG_STRAP_1_OUT = s_q.pin.cfg[1];
  assign BUS_CFG_STRAP_2_OUT = s_q.pin.cfg[2];
  assign ENDIAN_STRAP_OUT = s_q.pin.endian;
  assign BUS_STATUS_STRAP_N_OUT = s_q.pin.bs_n;
  assign RD_WR_STRAP_OUT = s_q.pin.rdwr;
endmodule
`default_nettype wire

/* File: tb/lcdhp_dev_model.sv */
// behavioural model of the lcd controller generic host port
`timescale 1ns/10ps
`default_nettype none
module lcdhp_dev_model (
  // clocks, reset, straps
  input wire logic clk_in,
  input wire logic bclk_in,
  input wire logic rst_n_in,
  input wire logic [5:0] strap_in,
  // host bus
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic hb_n_in,
  input wire logic [16:0] addr_in,
  input wire logic [15:0] data_in,
  input wire logic [15:0] delay_in,
  output logic [15:0] data_out,
  output logic wait_n_out
);
  logic [5:0] mode_q; // straps taken at reset release
  logic [15:0] mem_q [16]; // 16 words only: upper address bits alias
  logic [15:0] last_q; // last level on the data lines
  logic [16:0] addr_q; // address of latest access
  logic [15:0] cnt_q; // wait cycles left
  logic [7:0] bclk_q; // bus clock rises seen
  logic hb_q;
  logic busy_q;
  logic act;
  initial begin
    busy_q = 1'b0;
    wait_n_out = 1'b1;
    bclk_q = 8'h00;
    for (int i = 0; i < 16; i++)
      mem_q[i] = 16'h0000;
  end
  // strobes count only while selected
  assign act = !cs_n_in && !(rd_n_in && wr_n_in);
  // released lines flip every cycle so stale data never looks valid
  assign data_out = (act && !rd_n_in) ? mem_q[addr_in[3:0]] : ~last_q;
  // straps sampled at the rising edge of reset
  always @(posedge rst_n_in) mode_q <= strap_in;
  // bus clock activity
  always @(posedge bclk_in) bclk_q <= bclk_q + 8'h01;
  // controls are asynchronous; a fast clock samples them
  always @(posedge clk_in) begin
    last_q <= data_out;
    if (!act) begin
      busy_q <= 1'b0;
      wait_n_out <= 1'b1;
    end else if (!busy_q) begin
      busy_q <= 1'b1;
      wait_n_out <= 1'b0;
      cnt_q <= delay_in;
      addr_q <= addr_in;
      hb_q <= hb_n_in;
    end else if (cnt_q != 16'h0000) begin
      cnt_q <= cnt_q - 16'h0001;
    end else if (!wait_n_out) begin
      wait_n_out <= 1'b1;
      if (!wr_n_in) begin
        mem_q[addr_in[3:0]] <= {hb_n_in ? mem_q[addr_in[3:0]][15:8] : data_in[15:8], data_in[7:0]};
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/lcdhp_host_properties.sv */
// pin assertions for the lcd host-side controller
`timescale 1ns/10ps
`default_nettype none
module lcdhp_host_properties (
  // clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  // device bus
  input wire logic [lcdhp_pkg::LCDHP_AW-1:0] HOST_ADDR_OUT,
  input wire logic HOST_DATA_OE_N_OUT,
  input wire logic PROC_LCD_WINDOW_SEL_N_OUT,
  input wire logic READ_STROBE_N_OUT,
  input wire logic WRITE_STROBE_N_OUT,
  input wire logic HIGH_BYTE_STROBE_N_OUT,
  input wire logic WAIT_N_IN,
  input wire logic HOST_BUS_CLOCK_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  a_write_framed: assert property (!WRITE_STROBE_N_OUT |-> !PROC_LCD_WINDOW_SEL_N_OUT && !HOST_DATA_OE_N_OUT)
    else $error("write strobe outside a write");
  a_read_framed: assert property (!READ_STROBE_N_OUT |-> !PROC_LCD_WINDOW_SEL_N_OUT && HOST_DATA_OE_N_OUT)
    else $error("read strobe outside a read");
  a_drive_selected: assert property (!HOST_DATA_OE_N_OUT |-> !PROC_LCD_WINDOW_SEL_N_OUT && READ_STROBE_N_OUT)
    else $error("data driven while deselected");
  a_select_leads: assert property ($fell(WRITE_STROBE_N_OUT) || $fell(READ_STROBE_N_OUT) |-> $past(PROC_LCD_WINDOW_SEL_N_OUT, 2) == 1'b0)
    else $error("strobe without select setup");
  a_wait_extends: assert property (!WAIT_N_IN && !(READ_STROBE_N_OUT && WRITE_STROBE_N_OUT) |=> !(READ_STROBE_N_OUT && WRITE_STROBE_N_OUT))
    else $error("strobe ended during wait");
  a_addr_steady: assert property (!PROC_LCD_WINDOW_SEL_N_OUT && $past(PROC_LCD_WINDOW_SEL_N_OUT) == 1'b0 |-> $stable(HOST_ADDR_OUT) && $stable(HIGH_BYTE_STROBE_N_OUT))
    else $error("address or byte strobe moved in cycle");
  a_select_release: assert property ($rose(WRITE_STROBE_N_OUT) || $rose(READ_STROBE_N_OUT) |-> ##[1:4] PROC_LCD_WINDOW_SEL_N_OUT)
    else $error("select not released");
  a_bus_clock: assert property ($rose(HOST_BUS_CLOCK_OUT) |-> HOST_BUS_CLOCK_OUT[*4] ##1 !HOST_BUS_CLOCK_OUT[*4] ##1 HOST_BUS_CLOCK_OUT)
    else $error("bus clock period wrong");
endmodule
bind lcdhp_host lcdhp_host_properties i_props (.SYS_CLK_IN(SYS_CLK_IN), .RST_N_IN(RST_N_IN),
  .HOST_ADDR_OUT(HOST_ADDR_OUT), .HOST_DATA_OE_N_OUT(HOST_DATA_OE_N_OUT), .WAIT_N_IN(WAIT_N_IN),
  .PROC_LCD_WINDOW_SEL_N_OUT(PROC_LCD_WINDOW_SEL_N_OUT), .READ_STROBE_N_OUT(READ_STROBE_N_OUT),
  .WRITE_STROBE_N_OUT(WRITE_STROBE_N_OUT), .HIGH_BYTE_STROBE_N_OUT(HIGH_BYTE_STROBE_N_OUT),
  .HOST_BUS_CLOCK_OUT(HOST_BUS_CLOCK_OUT));
`default_nettype wire

/* File: tb/lcdhp_host_tb.sv */
// self-checking bench for the lcd host-side controller
`timescale 1ns/10ps
`default_nettype none
module lcdhp_host_tb;
  import lcdhp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [LCDHP_RA-1:0] ra = 4'h0;
  logic [LCDHP_RW-1:0] wd = 32'h0000_0000;
  logic [15:0] dly = 16'h0000; // device wait length
  logic [LCDHP_RW-1:0] rdata;
  logic [16:0] addr;
  logic [15:0] hdo, ddat, bus;
  logic oe_n, cs_n, rd_n, wr_n, hb_n, wait_n, bclk, drst_n;
  logic [5:0] strap; // cfg 2..0, status, read/write, endian
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  assign bus = oe_n ? ddat : hdo; // the enabled party owns the wire
  initial begin
    forever #10 clk = ~clk;
  end
  lcdhp_host i_dut (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(ra), .REG_WDATA_IN(wd),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .HOST_ADDR_OUT(addr), .HOST_DATA_IN(bus),
    .HOST_DATA_OUT(hdo), .HOST_DATA_OE_N_OUT(oe_n), .PROC_LCD_WINDOW_SEL_N_OUT(cs_n),
    .READ_STROBE_N_OUT(rd_n), .WRITE_STROBE_N_OUT(wr_n), .HIGH_BYTE_STROBE_N_OUT(hb_n),
    .WAIT_N_IN(wait_n), .HOST_BUS_CLOCK_OUT(bclk), .DEV_RESET_N_OUT(drst_n),
    .BUS_CFG_STRAP_0_OUT(strap[3]), .BUS_CFG_STRAP_1_OUT(strap[4]), .BUS_CFG_STRAP_2_OUT(strap[5]),
    .ENDIAN_STRAP_OUT(strap[0]), .BUS_STATUS_STRAP_N_OUT(strap[2]), .RD_WR_STRAP_OUT(strap[1]));
  lcdhp_dev_model i_dev (.clk_in(clk), .bclk_in(bclk), .rst_n_in(drst_n), .strap_in(strap),
    .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n), .hb_n_in(hb_n), .addr_in(addr), .data_in(bus),
    .delay_in(dly), .data_out(ddat), .wait_n_out(wait_n));
  // -----------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // data stand only in the cycle after the read strobe
  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // one device cycle, polled until busy clears
  task automatic op(input logic [16:0] a, input logic [15:0] d, input logic [31:0] c, output logic [31:0] s);
    wreg(LCDHP_REG_ADDR, {15'h0000, a});
    wreg(LCDHP_REG_WDATA, {16'h0000, d});
    wreg(LCDHP_REG_CTRL, c);
    s = 32'hFFFF_FFFF;
    for (int i = 0; i < 200 && s[LCDHP_STAT_BUSY] !== 1'b0; i++)
      rreg(LCDHP_REG_STAT, s);
  endtask
  // -----------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------
  task automatic t_reset;
    logic [31:0] s;
    @(posedge clk);
    chk(32'({strap, drst_n, cs_n}), 32'h0000_00F9);
    rreg(LCDHP_REG_STAT, s);
    chk(s, 32'h0000_0000);
    rreg(4'h2, s);
    chk(s, 32'h0000_0000);
  endtask
  task automatic t_straps;
    for (int e = 1; e >= 0; e--) begin
      wreg(LCDHP_REG_CTRL, 32'h0000_0010 | 32'(e << 3));
      wreg(LCDHP_REG_CTRL, 32'(e << 3));
      repeat (2) @(posedge clk);
      chk(32'(i_dev.mode_q), 32'h0000_003E | 32'(e));
      chk(32'(drst_n), 32'h0000_0001);
    end
  endtask
  task automatic t_write;
    logic [31:0] s;
    op(17'h1_FFFF, 16'hA5C3, 32'h0000_0001, s);
    chk(32'(i_dev.mem_q[15]), 32'h0000_A5C3);
    chk({15'h0000, i_dev.addr_q}, 32'h0001_FFFF);
    chk(32'(i_dev.hb_q), 32'h0000_0000);
    op(17'h0_0005, 16'h127E, 32'h0000_0005, s);
    chk(32'(i_dev.mem_q[5]), 32'h0000_007E);
    chk(32'(i_dev.hb_q), 32'h0000_0001);
    chk(s & 32'h0007_0000, 32'h0002_0000);
  endtask
  task automatic t_read;
    logic [31:0] s;
    dly <= 16'h0028;
    op(17'h1_FFFF, 16'h0000, 32'h0000_0003, s);
    chk(s, 32'h0002_A5C3);
    dly <= 16'h0000;
    op(17'h0_0005, 16'h0000, 32'h0000_0003, s);
    chk(s, 32'h0002_007E);
  endtask
  task automatic t_bclk;
    logic [7:0] n;
    @(posedge clk);
    #1 n = i_dev.bclk_q;
    repeat (16) @(posedge clk);
    #1 chk(32'(i_dev.bclk_q - n), 32'h0000_0002);
  endtask
  task automatic test_done;
    if (errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_straps();
    t_write();
    t_read();
    t_bclk();
    test_done();
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      test_done();
    end
  end
endmodule
`default_nettype wire
